// file: pkg/tcdma_pkg.sv
package tcdma_pkg;

   // ----------------------------------------------------------------
   // Register offsets in the processor I/O space.
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_CH0_SRC    = 8'h20;
   localparam logic [7:0] OFS_CH0_DST    = 8'h23;
   localparam logic [7:0] OFS_CH0_COUNT  = 8'h26;
   localparam logic [7:0] OFS_CH1_MEM    = 8'h28;
   localparam logic [7:0] OFS_CH1_IO     = 8'h2b;
   localparam logic [7:0] OFS_CH1_COUNT  = 8'h2e;
   localparam logic [7:0] OFS_STATUS     = 8'h30;
   localparam logic [7:0] OFS_CH0_MODE   = 8'h31;
   localparam logic [7:0] OFS_CONTROL    = 8'h32;

   // ----------------------------------------------------------------
   // Status register field positions.
   // ----------------------------------------------------------------
   localparam int BIT_CH1_RUN    = 7;
   localparam int BIT_CH0_RUN    = 6;
   localparam int BIT_CH1_GATE_N = 5;
   localparam int BIT_CH0_GATE_N = 4;
   localparam int BIT_CH1_IRQ_EN = 3;
   localparam int BIT_CH0_IRQ_EN = 2;
   localparam int BIT_MASTER_RUN = 0;

   // Control register fields: request sense and channel 1 mode.
   localparam int BIT_CH0_EDGE   = 3;
   localparam int BIT_CH1_EDGE   = 2;
   localparam int BIT_CH1_DIR    = 1;
   localparam int BIT_CH1_DEC    = 0;

   // Mode codes for each end of a channel 0 transfer.
   localparam logic [1:0] MODE_INC   = 2'h0;
   localparam logic [1:0] MODE_DEC   = 2'h1;
   localparam logic [1:0] MODE_FIXED = 2'h2;
   localparam logic [1:0] MODE_IO    = 2'h3;

   // Reset values.
   localparam logic [7:0] RST_MODE    = 8'h00;
   localparam logic [7:0] RST_CONTROL = 8'h00;
   localparam logic [1:0] RST_WAITS   = 2'h0;

   // ----------------------------------------------------------------
   // Bus request carried out by the transfer engine.
   // ----------------------------------------------------------------
   typedef struct packed {
      logic        read;
      logic        write;
      logic        io;
      logic [19:0] addr;
   } tcdma_bus_s;

   typedef enum logic [3:0] {
      ST_IDLE  = 4'b0001,
      ST_READ  = 4'b0010,
      ST_WRITE = 4'b0100,
      ST_DONE  = 4'b1000
   } tcdma_state_e;

endpackage : tcdma_pkg

// file: src/tcdma_core.sv
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Memory addresses are 20 bits and roll freely past 64k boundaries.
// - I/O addresses are 16 bits, covering the whole I/O space.
// - Each channel counts up to 65535 bytes in one 16-bit counter.
// - Request input senses level or falling edge, chosen by software.
// - Active-low end output tells outside devices a transfer finished.
// - Without waits one byte takes three bus cycles; waits stretch them.
// - Channel 0 wins when both channels want the bus.
// - Channel 0 moves memory, I/O, mapped I/O with inc, dec or hold.
// - Channel 0 source register supplies the 20-bit source address.
// - Channel 0 destination register supplies the destination address.
// - Software loads the byte count; each byte decrements it by one.
// - Channel 1 memory register is source or destination by direction.
// - Channel 1 I/O register is source or destination I/O address.
// - Channel runs with own and master enables; zero count clears own.
// - Stopped channel with done-interrupt enable raises an interrupt.
// - Software changes an enable bit only when its write gate is written as 0.
// - Gated write of 1 starts the channel and sets master enable.
// - Gated write of 0 stops the channel but keeps its registers.
// - Write gates store nothing and always read as 1.
// - Status layout: enables 7,6; gates 5,4; irq 3,2; master 0.
// - Status read shows each channel in progress or completed.
// - Non-maskable interrupt clears master enable; reset clears it too.
// - Channel 0 with an I/O end is paced by the request input.
module tcdma_core
   import tcdma_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic        rst,
   input  wire logic        clk_en,
   // Register port in the processor I/O space.
   input  wire logic [7:0]  reg_addr,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   input  wire logic [7:0]  reg_wdata,
   output logic      [7:0]  reg_rdata,
   // Events and pins.
   input  wire logic        nmi,
   input  wire logic        ch0_transfer_request_n,
   input  wire logic        ch1_transfer_request_n,
   output logic             last_transfer_n,
   output logic             done_irq,
   // System bus master side.
   output logic             bus_request,
   input  wire logic        bus_grant,
   input  wire logic        bus_wait,
   output logic      [19:0] bus_addr,
   output logic             bus_read,
   output logic             bus_write,
   output logic             bus_io,
   input  wire logic [7:0]  bus_rdata,
   output logic      [7:0]  bus_wdata
);

   // ----------------------------------------------------------------
   // Request pin synchronisers.
   // ----------------------------------------------------------------
   logic [1:0] req0_sync_reg, req0_sync_next;
   logic [1:0] req1_sync_reg, req1_sync_next;
   logic [1:0] req_prev_reg,  req_prev_next;
   logic [1:0] req_edge_reg,  req_edge_next;
   logic [1:0] req_active;

   // Second stage feeds the level sense and the edge detectors; first stage feeds nothing else.
   always_comb begin
      req0_sync_next = {req0_sync_reg[0], ch0_transfer_request_n};
      req1_sync_next = {req1_sync_reg[0], ch1_transfer_request_n};
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         req0_sync_reg <= 2'h3;
         req1_sync_reg <= 2'h3;
      end else if (clk_en) begin
         req0_sync_reg <= req0_sync_next;
         req1_sync_reg <= req1_sync_next;
      end
   end

   // ----------------------------------------------------------------
   // Registers.
   // ----------------------------------------------------------------
   logic [19:0] src_reg, src_next;                 // Channel 0 source.
   logic [19:0] dst_reg, dst_next;                 // Channel 0 destination.
   logic [15:0] cnt0_reg, cnt0_next;
   logic [19:0] mem1_reg, mem1_next;
   logic [15:0] io1_reg, io1_next;
   logic [15:0] cnt1_reg, cnt1_next;
   logic [1:0]  run_reg, run_next;                 // Channel enables.
   logic [1:0]  ien_reg, ien_next;
   logic        master_reg, master_next;
   logic [7:0]  mode_reg, mode_next;
   logic [7:0]  ctrl_reg, ctrl_next;
   logic [7:0]  rdata_reg, rdata_next;
   logic        irq_reg, irq_next;

   // Engine state.
   tcdma_state_e state_reg, state_next;
   logic         chan_reg, chan_next;              // Channel being served.
   logic [7:0]   data_reg, data_next;
   tcdma_bus_s   bus_reg, bus_next;
   logic         breq_reg, breq_next;
   logic         last_transfer_n_reg, last_transfer_n_next;

   logic [1:0] mode_src, mode_dst;
   logic       ch0_paced, ch1_to_io;
   logic [1:0] want;
   logic       gate0, gate1, last_byte;

   assign mode_src  = mode_reg[3:2];
   assign mode_dst  = mode_reg[5:4];
   assign ch0_paced = (mode_src == MODE_IO) || (mode_dst == MODE_IO);
   assign ch1_to_io = !ctrl_reg[BIT_CH1_DIR];

   // Level sense is the synchronised low level; edge sense latches a fall.
   assign req_active[0] = ctrl_reg[BIT_CH0_EDGE] ? req_edge_reg[0]
                                                : !req0_sync_reg[1];
   assign req_active[1] = ctrl_reg[BIT_CH1_EDGE] ? req_edge_reg[1]
                                                : !req1_sync_reg[1];

   // Channel 0 memory-to-memory free-runs; the rest wait for a request.
   assign want[0] = run_reg[0] && master_reg && cnt0_reg != 16'h0000
                    && (!ch0_paced || req_active[0]);
   assign want[1] = run_reg[1] && master_reg && cnt1_reg != 16'h0000
                    && req_active[1];

   assign gate0 = reg_wr && reg_addr == OFS_STATUS
                  && !reg_wdata[BIT_CH0_GATE_N];
   assign gate1 = reg_wr && reg_addr == OFS_STATUS
                  && !reg_wdata[BIT_CH1_GATE_N];

   // Address step: increment, decrement or hold for channel 0 ends.
   function automatic logic [19:0] step(input logic [19:0] a,
                                         input logic [1:0]  m);
      logic [19:0] r;
      r = a;
      if (m == MODE_INC)
         r = a + 20'h00001;
      else if (m == MODE_DEC)
         r = a - 20'h00001;
      return r;
   endfunction : step

   // ----------------------------------------------------------------
   // Next-state logic for registers and the engine.
   // ----------------------------------------------------------------
   always_comb begin
      src_next    = src_reg;
      dst_next    = dst_reg;
      cnt0_next   = cnt0_reg;
      mem1_next   = mem1_reg;
      io1_next    = io1_reg;
      cnt1_next   = cnt1_reg;
      run_next    = run_reg;
      ien_next    = ien_reg;
      master_next = master_reg;
      mode_next   = mode_reg;
      ctrl_next   = ctrl_reg;
      state_next  = state_reg;
      chan_next   = chan_reg;
      data_next   = data_reg;
      bus_next    = bus_reg;
      breq_next   = breq_reg;
      last_transfer_n_next   = 1'b1;
      last_byte   = 1'b0;
      req_prev_next = {req1_sync_reg[1], req0_sync_reg[1]};
      req_edge_next = req_edge_reg;
      // A falling edge is held until the engine uses it.
      if (req_prev_reg[0] && !req0_sync_reg[1])
         req_edge_next[0] = 1'b1;
      if (req_prev_reg[1] && !req1_sync_reg[1])
         req_edge_next[1] = 1'b1;

      // Register writes; multi-byte registers take one byte per offset.
      if (reg_wr) begin
         unique case (reg_addr)
            OFS_CH0_SRC:          src_next[7:0]   = reg_wdata;
            OFS_CH0_SRC + 8'h01:  src_next[15:8]  = reg_wdata;
            OFS_CH0_SRC + 8'h02:  src_next[19:16] = reg_wdata[3:0];
            OFS_CH0_DST:          dst_next[7:0]   = reg_wdata;
            OFS_CH0_DST + 8'h01:  dst_next[15:8]  = reg_wdata;
            OFS_CH0_DST + 8'h02:  dst_next[19:16] = reg_wdata[3:0];
            OFS_CH0_COUNT:        cnt0_next[7:0]  = reg_wdata;
            OFS_CH0_COUNT + 8'h01: cnt0_next[15:8] = reg_wdata;
            OFS_CH1_MEM:          mem1_next[7:0]   = reg_wdata;
            OFS_CH1_MEM + 8'h01:  mem1_next[15:8]  = reg_wdata;
            OFS_CH1_MEM + 8'h02:  mem1_next[19:16] = reg_wdata[3:0];
            OFS_CH1_IO:           io1_next[7:0]   = reg_wdata;
            OFS_CH1_IO + 8'h01:   io1_next[15:8]  = reg_wdata;
            OFS_CH1_COUNT:        cnt1_next[7:0]  = reg_wdata;
            OFS_CH1_COUNT + 8'h01: cnt1_next[15:8] = reg_wdata;
            OFS_STATUS: begin
               ien_next = {reg_wdata[BIT_CH1_IRQ_EN],
                           reg_wdata[BIT_CH0_IRQ_EN]};
               if (gate0)
                  run_next[0] = reg_wdata[BIT_CH0_RUN];
               if (gate1)
                  run_next[1] = reg_wdata[BIT_CH1_RUN];
               if ((gate0 && reg_wdata[BIT_CH0_RUN])
                   || (gate1 && reg_wdata[BIT_CH1_RUN]))
                  master_next = 1'b1;
            end
            OFS_CH0_MODE:  mode_next = reg_wdata;
            OFS_CONTROL:   ctrl_next = reg_wdata;
            default: ;
         endcase
      end

      // Engine: read cycle, write cycle, then release the bus.
      unique case (state_reg)
         ST_IDLE: begin
            breq_next = 1'b0;
            if (want != 2'b00) begin
               chan_next  = !want[0];
               breq_next  = 1'b1;
               state_next = ST_READ;
               if (!want[0]) begin
                  bus_next = ch1_to_io
                     ? '{1'b1, 1'b0, 1'b0, mem1_reg}
                     : '{1'b1, 1'b0, 1'b1, {4'h0, io1_reg}};
                  req_edge_next[1] = req_prev_reg[1] && !req1_sync_reg[1];
               end else begin
                  bus_next = '{1'b1, 1'b0, mode_src == MODE_IO,
                     mode_src == MODE_IO ? {4'h0, src_reg[15:0]}
                                         : src_reg};
                  req_edge_next[0] = req_prev_reg[0] && !req0_sync_reg[1];
               end
            end
         end
         ST_READ: begin
            if (bus_grant && !bus_wait) begin
               data_next  = bus_rdata;
               state_next = ST_WRITE;
               last_byte  = chan_reg ? cnt1_reg == 16'h0001
                                     : cnt0_reg == 16'h0001;
               last_transfer_n_next  = !last_byte;
               if (chan_reg)
                  bus_next = ch1_to_io
                     ? '{1'b0, 1'b1, 1'b1, {4'h0, io1_reg}}
                     : '{1'b0, 1'b1, 1'b0, mem1_reg};
               else
                  bus_next = '{1'b0, 1'b1, mode_dst == MODE_IO,
                     mode_dst == MODE_IO ? {4'h0, dst_reg[15:0]}
                                         : dst_reg};
            end
         end
         ST_WRITE: begin
            last_transfer_n_next = last_transfer_n || (bus_grant && !bus_wait);
            if (bus_grant && !bus_wait) begin
               bus_next   = '{1'b0, 1'b0, 1'b0, bus_reg.addr};
               breq_next  = 1'b0;
               state_next = ST_DONE;
               if (chan_reg) begin
                  cnt1_next = cnt1_reg - 16'h0001;
                  mem1_next = ctrl_reg[BIT_CH1_DEC]
                              ? mem1_reg - 20'h00001
                              : mem1_reg + 20'h00001;
                  if (cnt1_reg == 16'h0001)
                     run_next[1] = 1'b0;
               end else begin
                  cnt0_next = cnt0_reg - 16'h0001;
                  src_next  = step(src_reg, mode_src);
                  dst_next  = step(dst_reg, mode_dst);
                  if (cnt0_reg == 16'h0001)
                     run_next[0] = 1'b0;
               end
            end
         end
         ST_DONE: begin
            state_next = ST_IDLE;                     // Third bus cycle.
         end
         default: state_next = ST_IDLE;
      endcase

      // Non-maskable interrupt halts all channels; it outranks a start.
      if (nmi)
         master_next = 1'b0;
   end

   // Read data and interrupt request.
   always_comb begin
      rdata_next = 8'h00;
      unique case (reg_addr)
         OFS_CH0_SRC:           rdata_next = src_reg[7:0];
         OFS_CH0_SRC + 8'h01:   rdata_next = src_reg[15:8];
         OFS_CH0_SRC + 8'h02:   rdata_next = {4'h0, src_reg[19:16]};
         OFS_CH0_DST:           rdata_next = dst_reg[7:0];
         OFS_CH0_DST + 8'h01:   rdata_next = dst_reg[15:8];
         OFS_CH0_DST + 8'h02:   rdata_next = {4'h0, dst_reg[19:16]};
         OFS_CH0_COUNT:         rdata_next = cnt0_reg[7:0];
         OFS_CH0_COUNT + 8'h01: rdata_next = cnt0_reg[15:8];
         OFS_CH1_MEM:           rdata_next = mem1_reg[7:0];
         OFS_CH1_MEM + 8'h01:   rdata_next = mem1_reg[15:8];
         OFS_CH1_MEM + 8'h02:   rdata_next = {4'h0, mem1_reg[19:16]};
         OFS_CH1_IO:            rdata_next = io1_reg[7:0];
         OFS_CH1_IO + 8'h01:    rdata_next = io1_reg[15:8];
         OFS_CH1_COUNT:         rdata_next = cnt1_reg[7:0];
         OFS_CH1_COUNT + 8'h01: rdata_next = cnt1_reg[15:8];
         OFS_STATUS:
            rdata_next = {run_reg, 2'b11, ien_reg, 1'b0,
                          master_reg};
         OFS_CH0_MODE:          rdata_next = mode_reg;
         OFS_CONTROL:           rdata_next = ctrl_reg;
         default:               rdata_next = 8'h00;
      endcase
      irq_next = (!run_next[0] && ien_next[0])
                 || (!run_next[1] && ien_next[1]);
   end

   // ----------------------------------------------------------------
   // State registers.
   // ----------------------------------------------------------------
   // Address and count registers are cleared too, so that a stray start
   // after reset does nothing: a zero count never asks for the bus.
   always_ff @(posedge core_clk) begin
      if (rst) begin
         src_reg    <= 20'h00000;
         dst_reg    <= 20'h00000;
         cnt0_reg   <= 16'h0000;
         mem1_reg   <= 20'h00000;
         io1_reg    <= 16'h0000;
         cnt1_reg   <= 16'h0000;
         run_reg    <= 2'h0;
         ien_reg    <= 2'h0;
         master_reg <= 1'b0;
         mode_reg   <= RST_MODE;
         ctrl_reg   <= RST_CONTROL;
         rdata_reg  <= 8'h00;
         irq_reg    <= 1'b0;
         state_reg  <= ST_IDLE;
         chan_reg   <= 1'b0;
         data_reg   <= 8'h00;
         bus_reg    <= '0;
         breq_reg   <= 1'b0;
         last_transfer_n_reg   <= 1'b1;
         req_prev_reg <= 2'h3;
         req_edge_reg <= 2'h0;
      end else if (clk_en) begin
         src_reg    <= src_next;
         dst_reg    <= dst_next;
         cnt0_reg   <= cnt0_next;
         mem1_reg   <= mem1_next;
         io1_reg    <= io1_next;
         cnt1_reg   <= cnt1_next;
         run_reg    <= run_next;
         ien_reg    <= ien_next;
         master_reg <= master_next;
         mode_reg   <= mode_next;
         ctrl_reg   <= ctrl_next;
         rdata_reg  <= reg_rd ? rdata_next : rdata_reg;
         irq_reg    <= irq_next;
         state_reg  <= state_next;
         chan_reg   <= chan_next;
         data_reg   <= data_next;
         bus_reg    <= bus_next;
         breq_reg   <= breq_next;
         last_transfer_n_reg   <= last_transfer_n_next;
         req_prev_reg <= req_prev_next;
         req_edge_reg <= req_edge_next;
      end
   end

   // Outputs straight from flip-flops.
   assign reg_rdata       = rdata_reg;
   assign done_irq        = irq_reg;
   assign last_transfer_n = last_transfer_n_reg;
   assign bus_request     = breq_reg;
   assign bus_addr        = bus_reg.addr;
   assign bus_read        = bus_reg.read;
   assign bus_write       = bus_reg.write;
   assign bus_io          = bus_reg.io;
   assign bus_wdata       = data_reg;

   // ----------------------------------------------------------------
   // Assertions.
   // ----------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   // A start that meets the last byte's completion loses to the clear.
   sequence s_gated_start0;
      clk_en && gate0 && reg_wdata[BIT_CH0_RUN] && !nmi
      && !(state_reg == ST_WRITE && !chan_reg && cnt0_reg == 16'h0001);
   endsequence

   gated_start_a: assert property (s_gated_start0 |=> run_reg[0]
      && master_reg) else $error("gated start failed");
   ungated_hold_a: assert property (clk_en && reg_wr
      && reg_addr == OFS_STATUS && reg_wdata[BIT_CH0_GATE_N]
      && state_reg != ST_WRITE |=> $stable(run_reg[0]))
      else $error("enable changed without gate");
   nmi_clear_a: assert property (clk_en && nmi |=> !master_reg)
      else $error("master enable survived nmi");
   gate_read_a: assert property (clk_en && reg_rd
      && reg_addr == OFS_STATUS |=> reg_rdata[5:4] == 2'b11)
      else $error("write gates read not one");
   count_step_a: assert property (clk_en && state_reg == ST_WRITE
      && bus_grant && !bus_wait && !chan_reg
      |=> cnt0_reg == $past(cnt0_reg) - 16'h0001)
      else $error("count not decremented");
   empty_stop_a: assert property (clk_en && state_reg == ST_WRITE
      && bus_grant && !bus_wait && !chan_reg && cnt0_reg == 16'h0001
      |=> !run_reg[0])
      else $error("enable not cleared at zero");
   priority_a: assert property (clk_en && state_reg == ST_IDLE
      && want[0] |=> !chan_reg)
      else $error("channel 1 beat channel 0");
   release_a: assert property (state_reg == ST_DONE |-> !bus_request)
      else $error("bus held between transfers");
   irq_level_a: assert property (clk_en && !run_next[0] && ien_next[0]
      |=> done_irq) else $error("done interrupt missing");

endmodule : tcdma_core
`default_nettype wire

// file: verif/tcdma_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module tcdma_mem_model (
   input  wire logic        core_clk,
   input  wire logic        slow,
   input  wire logic        bus_request,
   input  wire logic [19:0] bus_addr,
   input  wire logic        bus_read,
   input  wire logic        bus_write,
   input  wire logic [7:0]  bus_wdata,
   output logic             bus_grant,
   output logic             bus_wait,
   output logic      [7:0]  bus_rdata
);
   logic [7:0] mem [256];
   logic [7:0] tick = 8'h00;
   // Grant follows request; slow mode stalls every other cycle.
   assign bus_grant = bus_request;
   assign bus_wait  = slow & tick[0];
   // Idle data lines move every cycle so a stale byte never looks valid.
   assign bus_rdata = bus_read ? mem[bus_addr[7:0]] : tick;
   // Memory starts with a known pattern and takes completed writes.
   initial for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5a;
   always @(posedge core_clk) begin
      tick <= tick + 8'h01;
      if (bus_write & bus_grant & !bus_wait) mem[bus_addr[7:0]] <= bus_wdata;
   end
endmodule : tcdma_mem_model
`default_nettype wire

// file: verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import tcdma_pkg::*;
   logic        core_clk, rst, reg_wr, reg_rd, nmi, slow, req1_n;
   logic [7:0]  reg_addr, reg_wdata, reg_rdata, bus_rdata, bus_wdata;
   logic        bus_request, bus_grant, bus_wait, bus_read, bus_write, bus_io;
   logic        last_transfer_n, done_irq;
   logic [19:0] bus_addr;
   int          miscompares = 0;
   int          checks_done = 0;
   int          last_transfer_n_cycles = 0;
   int          io_writes = 0;
   int          last_transfer_n_base = 0;
   tcdma_core dut_u (.core_clk, .rst, .clk_en(1'b1), .reg_addr, .reg_wr,
      .reg_rd, .reg_wdata, .reg_rdata, .nmi, .ch0_transfer_request_n(1'b1),
      .ch1_transfer_request_n(req1_n), .last_transfer_n, .done_irq,
      .bus_request, .bus_grant, .bus_wait, .bus_addr, .bus_read, .bus_write,
      .bus_io, .bus_rdata, .bus_wdata);
   tcdma_mem_model mem_u (.core_clk, .slow, .bus_request, .bus_addr,
      .bus_read, .bus_write, .bus_wdata, .bus_grant, .bus_wait, .bus_rdata);
   // ----------------------------------------------------------------
   // Access tasks and verdict.
   // ----------------------------------------------------------------
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge core_clk);
      reg_wr    <= 1'b0;
   endtask : wr
   // Read data is sampled one full cycle after the read edge.
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge core_clk);
      reg_rd   <= 1'b0;
      @(posedge core_clk);
      #1 chk(reg_rdata, exp);
   endtask : rd
   task automatic stop_test;
      if (miscompares == 0 && checks_done > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : stop_test
   // Free-running core clock.
   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end
   // Watchdog cuts a hang well past the expected run length.
   initial begin
      #2000000;
      miscompares++;
      stop_test();
   end
   // Bus monitor: cycles with the end strobe low, completed I/O writes.
   always @(posedge core_clk) begin
      if (!last_transfer_n)
         last_transfer_n_cycles <= last_transfer_n_cycles + 1;
      if (bus_write && bus_io && bus_grant && !bus_wait)
         io_writes <= io_writes + 1;
   end
   // Main sequence: a memory-to-memory run across a 64k boundary, then a channel 1 memory-to-I/O run.
   initial begin
      rst = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0; nmi = 1'b0; slow = 1'b0;
      req1_n = 1'b1;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      repeat (16) @(posedge core_clk);
      rst <= 1'b0;
      rd(OFS_STATUS, 8'h30);
      rd(8'h2d, 8'h00);
      wr(OFS_CH0_SRC, 8'hff);
      wr(OFS_CH0_SRC + 8'h01, 8'hff);
      wr(OFS_CH0_SRC + 8'h02, 8'h00);
      wr(OFS_CH0_DST, 8'h10);
      wr(OFS_CH0_DST + 8'h01, 8'h00);
      wr(OFS_CH0_DST + 8'h02, 8'h02);
      wr(OFS_CH0_COUNT, 8'h02);
      wr(OFS_CH0_COUNT + 8'h01, 8'h00);
      rd(OFS_CH0_COUNT, 8'h02);
      slow <= 1'b1;
      wr(OFS_STATUS, 8'h64);
      for (int i = 0; i < 200 && done_irq !== 1'b1; i++) @(posedge core_clk);
      chk({7'h00, done_irq}, 8'h01);
      rd(OFS_STATUS, 8'h35);
      rd(OFS_CH0_COUNT, 8'h00);
      rd(OFS_CH0_SRC, 8'h01);
      rd(OFS_CH0_SRC + 8'h02, 8'h01);
      rd(OFS_CH0_DST, 8'h12);
      chk(mem_u.mem[8'h10], 8'ha5);
      chk(mem_u.mem[8'h11], 8'h5a);
      wr(OFS_STATUS, 8'h78);
      rd(OFS_STATUS, 8'h39);
      @(posedge core_clk);
      nmi <= 1'b1;
      @(posedge core_clk);
      nmi <= 1'b0;
      rd(OFS_STATUS, 8'h38);
      // Channel 1, memory to I/O, paced by a level request on its pin.
      @(posedge core_clk);
      slow <= 1'b0;
      last_transfer_n_base = last_transfer_n_cycles;
      wr(OFS_CH1_MEM, 8'h20);
      wr(OFS_CH1_IO, 8'h40);
      wr(OFS_CH1_COUNT, 8'h01);
      wr(OFS_STATUS, 8'h98);
      repeat (8) @(posedge core_clk);
      rd(OFS_CH1_COUNT, 8'h01);
      @(posedge core_clk);
      req1_n <= 1'b0;
      repeat (20) @(posedge core_clk);
      req1_n <= 1'b1;
      chk(mem_u.mem[8'h40], 8'h7a);
      chk(8'(io_writes), 8'h01);
      chk(8'(last_transfer_n_cycles - last_transfer_n_base), 8'h01);
      rd(OFS_CH1_MEM, 8'h21);
      rd(OFS_CH1_COUNT, 8'h00);
      rd(OFS_STATUS, 8'h39);
      stop_test();
   end
endmodule : tb_top
`default_nettype wire
